// >>> sbd_pkg.sv
/*
 Package for the subtract-with-borrow decoder: opcode byte values, field
 positions, reset values and the decoded-form enumeration and carriers.
 Assumes a byte-wide fetch stream on the core clock.
*/
package sbd_pkg;

    localparam logic [7:0] OP_ACC_IMM    = 8'hab;
    localparam logic [7:0] OP_REG_GROUP  = 8'h7b;
    localparam logic [7:0] OP_UPPER_IMM  = 8'h6b;
    localparam logic [7:0] PFX_LOWER     = 8'h3c;
    localparam logic [7:0] PFX_SFR       = 8'h01;
    localparam logic [7:0] OP_SHORT_IMM  = 8'h6b;
    localparam logic [7:0] OP_REG_REG    = 8'h8b;
    localparam logic [7:0] OP_ACC_UPPER  = 8'h9b;
    localparam logic [7:0] OP_SHORT_PAIR = 8'h2a;
    localparam logic [7:0] SUB_UU        = 8'h0b;
    localparam logic [7:0] SUB_UL        = 8'h1b;
    localparam logic [7:0] SUB_LU        = 8'h2b;
    localparam logic [7:0] SUB_LL        = 8'h3b;
    localparam logic [7:0] PFX_POINTER   = 8'h07;
    localparam logic [7:0] PTR_ACC_P16   = 8'h2b;
    localparam logic [7:0] PTR_ACC_P24   = 8'h3b;
    localparam logic [7:0] PTR_MEM_P16   = 8'hab;
    localparam logic [7:0] PTR_MEM_P24   = 8'hbb;

    localparam logic [3:0] NIB_REG_UPPER = 4'h0;
    localparam logic [3:0] NIB_REG_LOWER = 4'h1;
    localparam logic [3:0] NIB_REG_SFR   = 4'h2;
    localparam logic [3:0] NIB_REG_IMM   = 4'h3;
    localparam logic [3:0] NIB_UPPER_REG = 4'h4;
    localparam logic [3:0] NIB_LOWER_REG = 4'h5;
    localparam logic [3:0] NIB_SFR_REG   = 4'h6;

    localparam int REG_HI_POS   = 4;
    localparam int ZERO_BIT_POS = 3;
    localparam int SRC_LO_POS   = 0;
    localparam logic [7:0] BYTE_RESET   = 8'h00;
    localparam logic [2:0] COUNT_RESET  = 3'h0;
    localparam int        STREAM_DEPTH = 4;

    typedef enum logic [4:0] {
        SBD_NONE       = 5'h00,
        SBD_ACC_IMM    = 5'h01,
        SBD_REG_IMM    = 5'h02,
        SBD_UPPER_IMM  = 5'h03,
        SBD_LOWER_IMM  = 5'h04,
        SBD_SFR_IMM    = 5'h05,
        SBD_REG_REG    = 5'h06,
        SBD_REG_REG_X  = 5'h07,
        SBD_ACC_UPPER  = 5'h08,
        SBD_REG_UPPER  = 5'h09,
        SBD_REG_LOWER  = 5'h0a,
        SBD_UPPER_REG  = 5'h0b,
        SBD_LOWER_REG  = 5'h0c,
        SBD_REG_SFR    = 5'h0d,
        SBD_SFR_REG    = 5'h0e,
        SBD_UU         = 5'h0f,
        SBD_UL         = 5'h10,
        SBD_LU         = 5'h11,
        SBD_LL         = 5'h12,
        SBD_ACC_UP16   = 5'h13,
        SBD_ACC_LP16   = 5'h14,
        SBD_ACC_UP24   = 5'h15,
        SBD_ACC_LP24   = 5'h16,
        SBD_UP16_ACC   = 5'h17,
        SBD_LP16_ACC   = 5'h18,
        SBD_UP24_ACC   = 5'h19,
        SBD_LP24_ACC   = 5'h1a
    } sbd_form_t;

    typedef enum logic [2:0] {
        SBD_ST_IDLE = 3'b001,
        SBD_ST_READ = 3'b010,
        SBD_ST_DONE = 3'b100
    } sbd_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       valid;
    } sbd_byte_t;

    typedef struct packed {
        sbd_form_t  form;
        logic [3:0] dstReg;
        logic [2:0] srcReg;
        logic [7:0] offsetA;
        logic [7:0] offsetB;
        logic [7:0] immediate;
        logic       illegal;
    } sbd_decode_t;

endpackage : sbd_pkg

// >>> sbd_byte_store.sv
/*
 Small register store holding the bytes of one instruction as they arrive.
 Assumes writes come one byte per cycle from the decoder's own control.
*/
module sbd_byte_store
(
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       writeEnable,
    input  wire logic [1:0] writeIndex,
    input  wire logic [7:0] writeData,
    output logic [31:0]     bytes
);

    logic [7:0] store [sbd_pkg::STREAM_DEPTH];

    genvar g;
    generate
        for (g = 0; g < sbd_pkg::STREAM_DEPTH; g++)
        begin : gSlot
            always_ff @(posedge ref_clk)
            begin
                if (reset)
                    store[g] <= sbd_pkg::BYTE_RESET;
                else if (writeEnable && writeIndex == 2'(g))
                    store[g] <= writeData;
            end
            assign bytes[8*g +: 8] = store[g];
        end
    endgenerate

endmodule : sbd_byte_store

// >>> sbd_decoder.sv
/*
 Byte-wide subtract-with-borrow instruction decoder. Takes opcode and
 trailing bytes from the fetch unit by a valid/ready pair and presents the
 decoded form and its fields when the instruction is complete, holding them until the next completion.
 Assumes the fetch unit holds a byte steady until it is taken.
*/
// Functional notes
// RULE1 - AB then immediate: accumulator minus immediate with borrow.
// RULE2 - 7B, low nibble 3: register in high nibble minus third-byte immediate.
// RULE3 - 6B: upper short offset, then immediate.
// RULE4 - 3C 6B: lower short offset third, immediate fourth.
// RULE5 - 01 6B: special register offset third, immediate fourth.
// RULE6 - 8B: register pair byte, destination high nibble, bit3 zero, source low.
// RULE7 - 3C 8B: same register pair layout in third byte.
// RULE8 - 9B: accumulator minus upper short operand, offset second byte.
// RULE9 - 7B, nibble 0: register minus upper short, offset third byte.
// RULE10 - 7B, nibble 1: register minus lower short, offset third byte.
// RULE11 - 7B, nibble 4: upper short minus register, offset third byte.
// RULE12 - 7B, nibble 5: lower short minus register, offset third byte.
// RULE13 - 7B, nibble 2: register minus special register, offset third byte.
// RULE14 - 7B, nibble 6: special register minus register, offset third byte.
// RULE15 - 2A then 0B/1B/2B/3B: area pairing, source offset third, destination fourth.
// RULE16 - 07 2B: accumulator minus byte via upper 16-bit pointer, offset third.
// RULE17 - 3C 07 2B: accumulator minus byte via lower 16-bit pointer, offset fourth.
// RULE18 - 07 3B: accumulator minus byte via upper 24-bit pointer, offset third.
// RULE19 - 3C 07 3B: accumulator minus byte via lower 24-bit pointer, offset fourth.
// RULE20 - 07 AB: upper 16-bit pointed byte minus accumulator, offset third.
// RULE21 - 3C 07 AB: lower 16-bit pointed byte minus accumulator, offset fourth.
// RULE22 - 07 BB: upper 24-bit pointed byte minus accumulator, offset third.
// RULE23 - 3C 07 BB: lower 24-bit pointed byte minus accumulator, offset fourth.
// RULE24 - Every form subtracts source and carry from destination, updates flags.
// RULE25 - All trailing bytes are fetched in order before completion is signalled.
module sbd_decoder
(
    input  wire logic            ref_clk,
    input  wire logic            reset,
    input  wire sbd_pkg::sbd_byte_t fetchByte,
    output logic                 fetchReady,
    output sbd_pkg::sbd_decode_t decoded,
    output logic                 decodeDone,
    output logic                 subtractWithBorrow
);

    sbd_pkg::sbd_state_t state;
    sbd_pkg::sbd_state_t next_state;
    logic [2:0]          count;
    logic [31:0]         bytes;
    logic [7:0]          b [4];
    logic [2:0]          needLen;
    logic [2:0]          curLen;
    logic                take;
    logic                complete;
    sbd_pkg::sbd_decode_t next_decoded;
    logic [2:0]          next_count;
    logic                next_borrow;

    // Byte n of the instruction, with the byte being taken this cycle overlaid
    function automatic logic [7:0] byteAt(input logic [31:0] held, input logic [2:0] cnt,
                                          input logic [7:0] now, input int idx);
        if (3'(idx) == cnt)
            return now;
        return held[8*idx +: 8];
    endfunction : byteAt

    // Second-level opcodes of the pointer forms, shared by both prefixes
    function automatic logic isPtrOp(input logic [7:0] op);
        return op == sbd_pkg::PTR_ACC_P16
            || op == sbd_pkg::PTR_ACC_P24
            || op == sbd_pkg::PTR_MEM_P16
            || op == sbd_pkg::PTR_MEM_P24;
    endfunction : isPtrOp

    // Area-pairing byte of the short-to-short forms
    function automatic logic isPairSub(input logic [7:0] op);
        return op == sbd_pkg::SUB_UU
            || op == sbd_pkg::SUB_UL
            || op == sbd_pkg::SUB_LU
            || op == sbd_pkg::SUB_LL;
    endfunction : isPairSub

    // Gated by the registered ready so a byte is never taken while the fetch side sees ready low
    assign take = fetchReady && fetchByte.valid && state != sbd_pkg::SBD_ST_DONE;
    assign curLen = count + 3'h1;

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : gView
            assign b[g] = byteAt(bytes, count, fetchByte.data, g);
        end
    endgenerate

    // Length so far known from the bytes seen; zero means unrecognised
    always_comb
    begin
        needLen = 3'h0;
        if (b[0] == sbd_pkg::OP_ACC_IMM)
            needLen = 3'h2; // RULE1
        else if (b[0] == sbd_pkg::OP_UPPER_IMM)
            needLen = 3'h3; // RULE3
        else if (b[0] == sbd_pkg::OP_REG_REG || b[0] == sbd_pkg::OP_ACC_UPPER)
            needLen = 3'h2; // RULE6 RULE8
        else if (b[0] == sbd_pkg::OP_REG_GROUP)
            needLen = (curLen < 3'h2 || b[1][3:0] <= sbd_pkg::NIB_SFR_REG) ? 3'h3 : 3'h0;
        else if (b[0] == sbd_pkg::OP_SHORT_PAIR)
            needLen = (curLen < 3'h2 || isPairSub(b[1])) ? 3'h4 : 3'h0; // RULE15
        else if (b[0] == sbd_pkg::PFX_SFR)
            needLen = (curLen < 3'h2 || b[1] == sbd_pkg::OP_SHORT_IMM) ? 3'h4 : 3'h0; // RULE5
        else if (b[0] == sbd_pkg::PFX_POINTER)
            needLen = (curLen < 3'h2 || isPtrOp(b[1])) ? 3'h3 : 3'h0;
        else if (b[0] == sbd_pkg::PFX_LOWER)
        begin
            if (curLen < 3'h2)
                needLen = 3'h4;
            else if (b[1] == sbd_pkg::OP_SHORT_IMM)
                needLen = 3'h4; // RULE4
            else if (b[1] == sbd_pkg::OP_REG_REG)
                needLen = 3'h3; // RULE7
            else if (b[1] == sbd_pkg::PFX_POINTER)
                needLen = (curLen < 3'h3 || isPtrOp(b[2])) ? 3'h4 : 3'h0;
        end
    end

    // Completion once every trailing byte has been taken, or at once when the bytes seen are unrecognised
    assign complete = take && (needLen == 3'h0 || curLen == needLen); // RULE25

    assign next_count = complete ? sbd_pkg::COUNT_RESET : (take ? curLen : count);

    // Borrow-subtract asserted for every legal form of the group
    assign next_borrow = complete && !next_decoded.illegal; // RULE24

    // Field extraction from the whole instruction
    always_comb
    begin
        next_decoded = '0;
        next_decoded.form = sbd_pkg::SBD_NONE;
        next_decoded.illegal = (needLen == 3'h0);
        if (b[0] == sbd_pkg::OP_ACC_IMM)
        begin
            next_decoded.form = sbd_pkg::SBD_ACC_IMM; // RULE1
            next_decoded.immediate = b[1];
        end
        else if (b[0] == sbd_pkg::OP_UPPER_IMM)
        begin
            next_decoded.form = sbd_pkg::SBD_UPPER_IMM; // RULE3
            next_decoded.offsetA = b[1];
            next_decoded.immediate = b[2];
        end
        else if (b[0] == sbd_pkg::OP_REG_REG)
        begin
            next_decoded.form = sbd_pkg::SBD_REG_REG; // RULE6
            next_decoded.dstReg = b[1][sbd_pkg::REG_HI_POS +: 4];
            next_decoded.srcReg = b[1][sbd_pkg::SRC_LO_POS +: 3];
            next_decoded.illegal = b[1][sbd_pkg::ZERO_BIT_POS];
        end
        else if (b[0] == sbd_pkg::OP_ACC_UPPER)
        begin
            next_decoded.form = sbd_pkg::SBD_ACC_UPPER; // RULE8
            next_decoded.offsetA = b[1];
        end
        else if (b[0] == sbd_pkg::OP_REG_GROUP)
        begin
            next_decoded.dstReg = b[1][sbd_pkg::REG_HI_POS +: 4];
            next_decoded.offsetA = b[2];
            next_decoded.immediate = b[2];
            case (b[1][3:0])
                sbd_pkg::NIB_REG_IMM:   next_decoded.form = sbd_pkg::SBD_REG_IMM; // RULE2
                sbd_pkg::NIB_REG_UPPER: next_decoded.form = sbd_pkg::SBD_REG_UPPER; // RULE9
                sbd_pkg::NIB_REG_LOWER: next_decoded.form = sbd_pkg::SBD_REG_LOWER; // RULE10
                sbd_pkg::NIB_UPPER_REG: next_decoded.form = sbd_pkg::SBD_UPPER_REG; // RULE11
                sbd_pkg::NIB_LOWER_REG: next_decoded.form = sbd_pkg::SBD_LOWER_REG; // RULE12
                sbd_pkg::NIB_REG_SFR:   next_decoded.form = sbd_pkg::SBD_REG_SFR; // RULE13
                sbd_pkg::NIB_SFR_REG:   next_decoded.form = sbd_pkg::SBD_SFR_REG; // RULE14
                default:                next_decoded.form = sbd_pkg::SBD_NONE;
            endcase
        end
        else if (b[0] == sbd_pkg::OP_SHORT_PAIR)
        begin
            next_decoded.offsetA = b[2]; // RULE15
            next_decoded.offsetB = b[3];
            if (b[1] == sbd_pkg::SUB_UU)
                next_decoded.form = sbd_pkg::SBD_UU;
            else if (b[1] == sbd_pkg::SUB_UL)
                next_decoded.form = sbd_pkg::SBD_UL;
            else if (b[1] == sbd_pkg::SUB_LU)
                next_decoded.form = sbd_pkg::SBD_LU;
            else if (b[1] == sbd_pkg::SUB_LL)
                next_decoded.form = sbd_pkg::SBD_LL;
        end
        else if (b[0] == sbd_pkg::PFX_SFR && b[1] == sbd_pkg::OP_SHORT_IMM)
        begin
            next_decoded.form = sbd_pkg::SBD_SFR_IMM; // RULE5
            next_decoded.offsetA = b[2];
            next_decoded.immediate = b[3];
        end
        else if (b[0] == sbd_pkg::PFX_POINTER)
        begin
            next_decoded.offsetA = b[2];
            if (b[1] == sbd_pkg::PTR_ACC_P16)
                next_decoded.form = sbd_pkg::SBD_ACC_UP16; // RULE16
            else if (b[1] == sbd_pkg::PTR_ACC_P24)
                next_decoded.form = sbd_pkg::SBD_ACC_UP24; // RULE18
            else if (b[1] == sbd_pkg::PTR_MEM_P16)
                next_decoded.form = sbd_pkg::SBD_UP16_ACC; // RULE20
            else if (b[1] == sbd_pkg::PTR_MEM_P24)
                next_decoded.form = sbd_pkg::SBD_UP24_ACC; // RULE22
        end
        else if (b[0] == sbd_pkg::PFX_LOWER)
        begin
            if (b[1] == sbd_pkg::OP_SHORT_IMM)
            begin
                next_decoded.form = sbd_pkg::SBD_LOWER_IMM; // RULE4
                next_decoded.offsetA = b[2];
                next_decoded.immediate = b[3];
            end
            else if (b[1] == sbd_pkg::OP_REG_REG)
            begin
                next_decoded.form = sbd_pkg::SBD_REG_REG_X; // RULE7
                next_decoded.dstReg = b[2][sbd_pkg::REG_HI_POS +: 4];
                next_decoded.srcReg = b[2][sbd_pkg::SRC_LO_POS +: 3];
                next_decoded.illegal = b[2][sbd_pkg::ZERO_BIT_POS];
            end
            else if (b[1] == sbd_pkg::PFX_POINTER)
            begin
                next_decoded.offsetA = b[3];
                if (b[2] == sbd_pkg::PTR_ACC_P16)
                    next_decoded.form = sbd_pkg::SBD_ACC_LP16; // RULE17
                else if (b[2] == sbd_pkg::PTR_ACC_P24)
                    next_decoded.form = sbd_pkg::SBD_ACC_LP24; // RULE19
                else if (b[2] == sbd_pkg::PTR_MEM_P16)
                    next_decoded.form = sbd_pkg::SBD_LP16_ACC; // RULE21
                else if (b[2] == sbd_pkg::PTR_MEM_P24)
                    next_decoded.form = sbd_pkg::SBD_LP24_ACC; // RULE23
            end
        end
        if (next_decoded.form == sbd_pkg::SBD_NONE)
            next_decoded.illegal = 1'b1;
    end

    always_comb
    begin
        case (state)
            sbd_pkg::SBD_ST_IDLE: next_state = complete ? sbd_pkg::SBD_ST_DONE
                                             : (take ? sbd_pkg::SBD_ST_READ : sbd_pkg::SBD_ST_IDLE);
            sbd_pkg::SBD_ST_READ: next_state = complete ? sbd_pkg::SBD_ST_DONE : sbd_pkg::SBD_ST_READ;
            sbd_pkg::SBD_ST_DONE: next_state = sbd_pkg::SBD_ST_IDLE;
            default:              next_state = sbd_pkg::SBD_ST_IDLE;
        endcase
    end

    sbd_byte_store uStore
    (
        .ref_clk     (ref_clk),
        .reset       (reset),
        .writeEnable (take),
        .writeIndex  (count[1:0]),
        .writeData   (fetchByte.data),
        .bytes       (bytes)
    );

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            state <= sbd_pkg::SBD_ST_IDLE;
        else
            state <= next_state;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            count <= sbd_pkg::COUNT_RESET;
        else
            count <= next_count;
    end

    // Held until the next completion so the core may read it late
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            decoded <= '0;
        else if (complete)
            decoded <= next_decoded;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            decodeDone <= 1'b0;
        else
            decodeDone <= complete; // RULE25
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            subtractWithBorrow <= 1'b0;
        else
            subtractWithBorrow <= next_borrow; // RULE24
    end

    // Stall one cycle after completion so the result is seen before the next opcode
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            fetchReady <= 1'b0;
        else
            fetchReady <= (next_state != sbd_pkg::SBD_ST_DONE);
    end

endmodule : sbd_decoder

// >>> sbd_decoder_chk.sv
/*
 Port checker for the subtract-with-borrow decoder, bound to its top.
 Assumes one clock and a synchronous active-high reset.
*/
module sbd_decoder_chk
(
    input wire logic                 ref_clk,
    input wire logic                 reset,
    input wire sbd_pkg::sbd_byte_t   fetchByte,
    input wire logic                 fetchReady,
    input wire sbd_pkg::sbd_decode_t decoded,
    input wire logic                 decodeDone,
    input wire logic                 subtractWithBorrow
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    logic       first;
    logic [7:0] lastByte;
    wire        take = fetchByte.valid && fetchReady;
    wire        isPtr = decoded.form inside {[sbd_pkg::SBD_ACC_UP16:sbd_pkg::SBD_LP24_ACC]};
    wire        isPair = decoded.form inside {[sbd_pkg::SBD_UU:sbd_pkg::SBD_LL]};

    // Every form ends with the byte that carries its last field
    always_ff @(posedge ref_clk)
        if (take)
            lastByte <= fetchByte.data;

    always_ff @(posedge ref_clk)
        if (reset || decodeDone)
            first <= 1'b1;
        else if (take)
            first <= 1'b0;

    property p_refuse;
        decodeDone |-> !fetchReady;
    endproperty
    a_refuse: assert property (p_refuse) else $error("byte accepted in completion cycle");

    property p_pulse;
        decodeDone |=> !decodeDone && fetchReady;
    endproperty
    a_pulse: assert property (p_pulse) else $error("completion not a single pulse");

    property p_borrow;
        subtractWithBorrow |-> decodeDone && !decoded.illegal && decoded.form != sbd_pkg::SBD_NONE;
    endproperty
    a_borrow: assert property (p_borrow) else $error("borrow pulse without legal completion");

    property p_hold;
        !decodeDone |-> $stable(decoded);
    endproperty
    a_hold: assert property (p_hold) else $error("decoded result moved between completions");

    property p_acc_imm;
        (take && first && fetchByte.data == sbd_pkg::OP_ACC_IMM) ##1 take
        |=> decodeDone && decoded.form == sbd_pkg::SBD_ACC_IMM && decoded.immediate == lastByte;
    endproperty
    a_acc_imm: assert property (p_acc_imm) else $error("accumulator immediate form wrong");

    property p_regreg;
        decodeDone && decoded.form == sbd_pkg::SBD_REG_REG |-> decoded.dstReg == lastByte[7:4]
            && decoded.srcReg == lastByte[2:0] && decoded.illegal == lastByte[3];
    endproperty
    a_regreg: assert property (p_regreg) else $error("register pair fields wrong");

    property p_pair;
        decodeDone && isPair |-> decoded.offsetB == lastByte && decoded.offsetA == $past(lastByte);
    endproperty
    a_pair: assert property (p_pair) else $error("short pair offsets wrong");

    property p_ptr;
        decodeDone && isPtr |-> decoded.offsetA == lastByte && !decoded.illegal;
    endproperty
    a_ptr: assert property (p_ptr) else $error("pointer offset wrong");

    c_legal: cover property (decodeDone && !decoded.illegal);
    c_illegal: cover property (decodeDone && decoded.illegal);
    c_gap: cover property (!first && !fetchByte.valid);
endmodule : sbd_decoder_chk

bind sbd_decoder sbd_decoder_chk u_chk (.ref_clk(ref_clk), .reset(reset), .fetchByte(fetchByte),
    .fetchReady(fetchReady), .decoded(decoded), .decodeDone(decodeDone), .subtractWithBorrow(subtractWithBorrow));

// >>> sbd_fetch_model.sv
/*
 Fetch unit model: offers queued bytes by valid/ready, may stall.
 Assumes the bench pushes bytes into q between clock edges.
*/
module sbd_fetch_model
(
    input  wire logic          ref_clk,
    input  wire logic          reset,
    input  wire logic          stall,
    input  wire logic          fetchReady,
    output sbd_pkg::sbd_byte_t fetchByte
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] q[$];

    always @(posedge ref_clk)
    begin
        if (reset)
            fetchByte <= '{data: 8'h5a, valid: 1'b0};
        else if (!fetchByte.valid || fetchReady)
        begin
            // Idle data toggles so a stale byte never looks fresh
            if (q.size() > 0 && !stall)
                fetchByte <= '{data: q.pop_front(), valid: 1'b1};
            else
                fetchByte <= '{data: ~fetchByte.data, valid: 1'b0};
        end
    end
endmodule : sbd_fetch_model

// >>> tb.sv
/*
 Self-checking bench for the decoder: each form sent through the fetch model.
 Assumes the checker is bound to the decoder.
*/
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                 ref_clk;
    logic                 reset;
    logic                 stall;
    logic                 stallOn;
    logic                 fetchReady;
    logic                 decodeDone;
    logic                 subtractWithBorrow;
    sbd_pkg::sbd_byte_t   fetchByte;
    sbd_pkg::sbd_decode_t decoded;
    int                   bad_count;
    int                   n_tests;

    sbd_fetch_model fetch (.ref_clk(ref_clk), .reset(reset), .stall(stall), .fetchReady(fetchReady),
        .fetchByte(fetchByte));
    sbd_decoder DUT (.ref_clk(ref_clk), .reset(reset), .fetchByte(fetchByte), .fetchReady(fetchReady),
        .decoded(decoded), .decodeDone(decodeDone), .subtractWithBorrow(subtractWithBorrow));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
        stall <= stallOn & ~stall;

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    task automatic cmp_form(input sbd_pkg::sbd_form_t exp, input sbd_pkg::sbd_form_t got);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED form expected %h seen %h", exp, got);
        end
    endtask : cmp_form

    // Mask bits select dstReg, srcReg, offsetA, offsetB, immediate
    task automatic run(input logic [31:0] b, input int n, input sbd_pkg::sbd_form_t f, input logic [4:0] m,
        input logic [3:0] dr, input logic [2:0] sr, input logic [7:0] oa, ob, im, input logic ill);
        int i;
        for (i = 0; i < n; i++)
            fetch.q.push_back(b[31 - 8 * i -: 8]);
        i = 0;
        while (decodeDone !== 1'b1)
        begin
            @(posedge ref_clk);
            #1;
            i++;
            if (i > 60)
            begin
                bad_count++;
                $display("CHECK FAILED decodeDone expected 1 seen %b", decodeDone);
                test_done();
            end
        end
        cmp_form(f, decoded.form);
        cmp("illegal", {7'h0, ill}, {7'h0, decoded.illegal});
        cmp("borrow", {7'h0, ~ill}, {7'h0, subtractWithBorrow});
        cmp("fetchReady", 8'h00, {7'h0, fetchReady});
        cmp("pending", 8'h00, 8'(fetch.q.size()) + {7'h0, fetchByte.valid});
        if (m[0])
            cmp("dstReg", {4'h0, dr}, {4'h0, decoded.dstReg});
        if (m[1])
            cmp("srcReg", {5'h0, sr}, {5'h0, decoded.srcReg});
        if (m[2])
            cmp("offsetA", oa, decoded.offsetA);
        if (m[3])
            cmp("offsetB", ob, decoded.offsetB);
        if (m[4])
            cmp("immediate", im, decoded.immediate);
        @(posedge ref_clk);
        #1;
        cmp("fetchReady", 8'h01, {7'h0, fetchReady});
        cmp("decodeDone", 8'h00, {7'h0, decodeDone});
    endtask : run

    task automatic t_imm();
        run(32'hab5a0000, 2, sbd_pkg::SBD_ACC_IMM, 5'h10, '0, '0, '0, '0, 8'h5a, 1'b0);
        run(32'h7bc3a500, 3, sbd_pkg::SBD_REG_IMM, 5'h11, 4'hc, '0, '0, '0, 8'ha5, 1'b0);
        run(32'h6b12ff00, 3, sbd_pkg::SBD_UPPER_IMM, 5'h14, '0, '0, 8'h12, '0, 8'hff, 1'b0);
        run(32'h3c6b3400, 4, sbd_pkg::SBD_LOWER_IMM, 5'h14, '0, '0, 8'h34, '0, 8'h00, 1'b0);
        run(32'h016bfe81, 4, sbd_pkg::SBD_SFR_IMM, 5'h14, '0, '0, 8'hfe, '0, 8'h81, 1'b0);
    endtask : t_imm

    task automatic t_reg();
        run(32'h8ba70000, 2, sbd_pkg::SBD_REG_REG, 5'h03, 4'ha, 3'h7, '0, '0, '0, 1'b0);
        run(32'h3c8bf000, 3, sbd_pkg::SBD_REG_REG_X, 5'h03, 4'hf, 3'h0, '0, '0, '0, 1'b0);
        run(32'h8b580000, 2, sbd_pkg::SBD_REG_REG, 5'h00, '0, '0, '0, '0, '0, 1'b1);
        run(32'h9b770000, 2, sbd_pkg::SBD_ACC_UPPER, 5'h04, '0, '0, 8'h77, '0, '0, 1'b0);
    endtask : t_reg

    task automatic t_group();
        sbd_pkg::sbd_form_t grp[7] = '{sbd_pkg::SBD_REG_UPPER, sbd_pkg::SBD_REG_LOWER, sbd_pkg::SBD_REG_SFR,
            sbd_pkg::SBD_REG_IMM, sbd_pkg::SBD_UPPER_REG, sbd_pkg::SBD_LOWER_REG, sbd_pkg::SBD_SFR_REG};
        for (int k = 0; k < 7; k++)
            run({8'h7b, 4'(k + 9), 4'(k), 8'h40 + 8'(k), 8'h00}, 3, grp[k], 5'h15, 4'(k + 9), '0,
                8'h40 + 8'(k), '0, 8'h40 + 8'(k), 1'b0);
    endtask : t_group

    task automatic t_pair();
        for (int k = 0; k < 4; k++)
            run({8'h2a, 4'(k), 4'hb, 8'hc0 + 8'(k), 8'h0f}, 4, sbd_pkg::sbd_form_t'(sbd_pkg::SBD_UU + k), 5'h0c,
                '0, '0, 8'hc0 + 8'(k), 8'h0f, '0, 1'b0);
    endtask : t_pair

    // Lower forms run with the fetch side stalling every other cycle
    task automatic t_ptr();
        logic [7:0] op[4] = '{8'h2b, 8'h3b, 8'hab, 8'hbb};
        for (int k = 0; k < 4; k++)
        begin
            stallOn = 1'b0;
            run({8'h07, op[k], 8'h90 + 8'(k), 8'h00}, 3, sbd_pkg::sbd_form_t'(sbd_pkg::SBD_ACC_UP16 + 2 * k),
                5'h04, '0, '0, 8'h90 + 8'(k), '0, '0, 1'b0);
            stallOn = 1'b1;
            run({8'h3c, 8'h07, op[k], 8'hff - 8'(k)}, 4, sbd_pkg::sbd_form_t'(sbd_pkg::SBD_ACC_LP16 + 2 * k),
                5'h04, '0, '0, 8'hff - 8'(k), '0, '0, 1'b0);
        end
        stallOn = 1'b0;
    endtask : t_ptr

    task automatic t_bad();
        run(32'h00000000, 1, sbd_pkg::SBD_NONE, 5'h00, '0, '0, '0, '0, '0, 1'b1);
        run(32'h7b070000, 2, sbd_pkg::SBD_NONE, 5'h00, '0, '0, '0, '0, '0, 1'b1);
        run(32'h2a4b0000, 2, sbd_pkg::SBD_NONE, 5'h00, '0, '0, '0, '0, '0, 1'b1);
        run(32'h3c000000, 2, sbd_pkg::SBD_NONE, 5'h00, '0, '0, '0, '0, '0, 1'b1);
        run(32'h07000000, 2, sbd_pkg::SBD_NONE, 5'h00, '0, '0, '0, '0, '0, 1'b1);
    endtask : t_bad

    initial
    begin
        bad_count = 0;
        n_tests = 0;
        reset = 1'b1;
        stallOn = 1'b0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_imm();
        t_reg();
        t_group();
        t_pair();
        t_ptr();
        t_bad();
        test_done();
    end
endmodule : tb
